//--- rpf_framer.sv
// Builds the serial output frame for one received radio packet
// Assumes intake and sink logic on ref_clk; sink takes a byte every cycle
//
// Summary of operation
// - Frame opens with start delimiter byte
// - Length counts bytes between length and checksum
// - Standard frame type byte is received-packet code
// - Standard frame only when output select zero
// - Sender 64-bit address at offsets four-eleven
// - Reserved word at twelve, all ones but LSB
// - Options bit0 acknowledged, bit1 broadcast
// - Options bits 7:6 delivery method, 00 invalid
// - Option flags combine by bitwise OR
// - Payload from offset fifteen, variable length
// - Checksum is FF minus sum from type
// - Select bit1 set gives explicit frame type
`timescale 1ns/10ps
`default_nettype none
`include "rpf_params.svh"

module rpf_framer (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // Packet intake
  input  wire logic        pkt_wr_valid,
  input  wire logic [7:0]  pkt_wr_data,
  input  wire logic        pkt_commit,
  input  wire logic [63:0] pkt_src_addr,
  input  wire logic        pkt_acked,
  input  wire logic        pkt_bcast,
  input  wire logic [1:0]  pkt_method,
  input  wire logic [7:0]  api_output_select,
  // Intake status
  output logic             pkt_ready,
  output logic             pkt_drop,
  // Frame byte stream
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  output logic             tx_sof,
  output logic             tx_eof
);

  // Control state
  rpf_pkg::rpf_state_t state_r;     // Emission phase
  rpf_pkg::rpf_state_t state_nxt;   // Next phase
  logic [8:0]          wr_cnt_r;    // Payload bytes stored
  logic [3:0]          idx_r;       // Header byte offset
  logic [7:0]          pay_idx_r;   // Payload byte being sent
  logic [7:0]          sum_r;       // Running checksum sum
  // Latched packet header
  logic [15:0]         len_r;       // Length field value
  logic [8:0]          n_r;         // Payload byte count
  logic [63:0]         src_r;       // Sender address
  logic [7:0]          opt_r;       // Receive options byte
  logic                expl_r;      // Explicit frame type chosen
  // Output flops
  logic                tx_valid_r;
  logic [7:0]          tx_data_r;
  logic                tx_sof_r;
  logic                tx_eof_r;
  logic                pkt_ready_r;
  logic                pkt_drop_r;

  // Intake decode
  logic       commit_go;    // Commit seen while idle
  logic       mode_std;     // Standard output selected
  logic       mode_expl;    // Explicit output selected
  logic       meth_ok;      // Delivery method valid
  logic       frame_go;     // Packet becomes a frame
  logic       wr_go;        // Payload byte stored
  logic [8:0] wr_cnt_inc;
  logic [8:0] pay_n;        // Count including this cycle's byte
  logic [7:0] opt_byte;     // Assembled options
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic [7:0] hdr_byte [0:14];
  logic [7:0] byte_nxt;
  logic       hdr_done;
  logic       pay_done;
  logic       sum_en;
  logic [15:0] rsvd_word;   // Reserved field, split into two bytes below

  assign commit_go  = pkt_commit && pkt_ready_r;
  assign mode_std   = api_output_select == `RPF_SEL_STD;
  assign mode_expl  = api_output_select[`RPF_SEL_EXPL_BIT];
  assign meth_ok    = pkt_method != `RPF_METH_INVALID;
  // Other select values are not ours to frame, so the packet is dropped
  assign frame_go   = commit_go && (mode_std || mode_expl) && meth_ok;
  // Bytes past the store depth are discarded, not wrapped
  assign wr_go      = pkt_wr_valid && pkt_ready_r && (wr_cnt_r != `RPF_PAY_DEPTH);
  assign wr_cnt_inc = wr_cnt_r + 9'h001;
  assign pay_n      = wr_go ? wr_cnt_inc : wr_cnt_r;
  // Flags merge by OR into one byte, reserved bits zero
  assign opt_byte   = {pkt_method, 4'h0, pkt_bcast, pkt_acked};

  // Header bytes in send order, most significant first
  assign hdr_byte[0]  = `RPF_START_DELIM;
  assign hdr_byte[1]  = len_r[15:8];
  assign hdr_byte[2]  = len_r[7:0];
  assign hdr_byte[3]  = expl_r ? `RPF_TYPE_EXPL : `RPF_TYPE_STD;
  for (genvar gi = 0; gi < 8; gi++) begin : g_src
    assign hdr_byte[4+gi] = src_r[63-8*gi -: 8];
  end
  // Named word so each byte is an explicit part-select, no silent truncation
  assign rsvd_word    = `RPF_RSVD_WORD;
  assign hdr_byte[12] = rsvd_word[15:8];
  assign hdr_byte[13] = rsvd_word[7:0];
  assign hdr_byte[14] = opt_r;

  // Sequencing decode
  assign hdr_done = idx_r == `RPF_HDR_LAST;
  assign pay_done = {1'b0, pay_idx_r} == (n_r - 9'h001);
  // Read one byte ahead so the registered store keeps the stream gapless
  assign rd_addr  = (state_r == rpf_pkg::RPF_DATA) ? pay_idx_r + 8'h01 : 8'h00;
  assign sum_en   = ((state_r == rpf_pkg::RPF_HEAD) && (idx_r >= `RPF_CSUM_FIRST))
                 || (state_r == rpf_pkg::RPF_DATA);

  // Byte chosen for the next output cycle
  always_comb begin
    unique case (state_r)
      rpf_pkg::RPF_HEAD: byte_nxt = hdr_byte[idx_r];
      rpf_pkg::RPF_DATA: byte_nxt = rd_data;
      rpf_pkg::RPF_CSUM: byte_nxt = `RPF_CSUM_BASE - sum_r;
      rpf_pkg::RPF_IDLE: byte_nxt = 8'h00;
    endcase
  end

  // Phase transitions
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      rpf_pkg::RPF_IDLE: if (frame_go) state_nxt = rpf_pkg::RPF_HEAD;
      // Empty payload goes straight to the checksum
      rpf_pkg::RPF_HEAD: if (hdr_done) begin
        state_nxt = (n_r == 9'h000) ? rpf_pkg::RPF_CSUM : rpf_pkg::RPF_DATA;
      end
      rpf_pkg::RPF_DATA: if (pay_done) state_nxt = rpf_pkg::RPF_CSUM;
      rpf_pkg::RPF_CSUM: state_nxt = rpf_pkg::RPF_IDLE;
    endcase
  end

  // Payload store
  rpf_payload_mem #(
    .AW        (`RPF_PAY_AW)
  ) u_mem (
    .ref_clk   (ref_clk),
    .wr_en     (wr_go),
    .wr_addr   (wr_cnt_r[7:0]),
    .wr_data   (pkt_wr_data),
    .rd_addr   (rd_addr),
    .rd_data_r (rd_data)
  );

  // Phase and counters
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r   <= rpf_pkg::RPF_IDLE;
      wr_cnt_r  <= 9'h000;
      idx_r     <= 4'h0;
      pay_idx_r <= 8'h00;
      sum_r     <= 8'h00;
    end else begin
      state_r   <= state_nxt;
      wr_cnt_r  <= commit_go ? 9'h000 : (wr_go ? wr_cnt_inc : wr_cnt_r);
      idx_r     <= frame_go ? 4'h0 : idx_r + {3'h0, state_r == rpf_pkg::RPF_HEAD};
      pay_idx_r <= frame_go ? 8'h00 : pay_idx_r + {7'h00, state_r == rpf_pkg::RPF_DATA};
      sum_r     <= frame_go ? 8'h00 : (sum_en ? sum_r + byte_nxt : sum_r);
    end
  end

  // Header fields caught when the packet is committed
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      len_r  <= 16'h0000;
      n_r    <= 9'h000;
      src_r  <= 64'h0000_0000_0000_0000;
      opt_r  <= 8'h00;
      expl_r <= 1'b0;
    end else if (frame_go) begin
      len_r  <= `RPF_FIXED_BYTES + {7'h00, pay_n};
      n_r    <= pay_n;
      src_r  <= pkt_src_addr;
      opt_r  <= opt_byte;
      expl_r <= mode_expl;
    end
  end

  // Output flops
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_valid_r  <= 1'b0;
      tx_data_r   <= 8'h00;
      tx_sof_r    <= 1'b0;
      tx_eof_r    <= 1'b0;
      pkt_ready_r <= 1'b0;
      pkt_drop_r  <= 1'b0;
    end else begin
      tx_valid_r  <= state_r != rpf_pkg::RPF_IDLE;
      tx_data_r   <= byte_nxt;
      tx_sof_r    <= (state_r == rpf_pkg::RPF_HEAD) && (idx_r == 4'h0);
      tx_eof_r    <= state_r == rpf_pkg::RPF_CSUM;
      pkt_ready_r <= state_nxt == rpf_pkg::RPF_IDLE;
      pkt_drop_r  <= commit_go && !frame_go;
    end
  end

  assign tx_valid  = tx_valid_r;
  assign tx_data   = tx_data_r;
  assign tx_sof    = tx_sof_r;
  assign tx_eof    = tx_eof_r;
  assign pkt_ready = pkt_ready_r;
  assign pkt_drop  = pkt_drop_r;

  // Checking helpers: byte position and independent sum
  logic [9:0] pos_h;
  logic [7:0] hsum_h;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_h  <= 10'h000;
      hsum_h <= 8'h00;
    end else if (tx_valid_r) begin
      pos_h  <= tx_eof_r ? 10'h000 : pos_h + 10'h001;
      hsum_h <= tx_eof_r ? 8'h00 : ((pos_h >= 10'h003) ? hsum_h + tx_data_r : hsum_h);
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_sof_delim: assert property (tx_sof_r |-> tx_data_r == 8'h7E)
    else $error("frame does not open with delimiter");
  a_len_order: assert property (
    tx_sof_r |=> tx_data_r == len_r[15:8] ##1 tx_data_r == len_r[7:0])
    else $error("length bytes wrong or out of order");
  a_frame_span: assert property (tx_eof_r |-> pos_h == len_r[9:0] + 10'h003)
    else $error("frame size disagrees with length");
  a_type_std: assert property (tx_sof_r && !expl_r |-> ##3 tx_data_r == 8'h90)
    else $error("standard frame type wrong");
  a_type_expl: assert property (tx_sof_r && expl_r |-> ##3 tx_data_r == 8'h91)
    else $error("explicit frame type wrong");
  a_src_addr: assert property (
    tx_sof_r |-> ##4 tx_data_r == src_r[63:56] ##7 tx_data_r == src_r[7:0])
    else $error("source address bytes wrong");
  a_rsvd_word: assert property (tx_sof_r |-> ##12 tx_data_r == 8'hFF ##1 tx_data_r == 8'hFE)
    else $error("reserved word wrong");
  a_opt_byte: assert property (
    tx_sof_r |-> ##14 tx_data_r[5:2] == 4'h0 && tx_data_r[7:6] != 2'h0)
    else $error("options byte malformed");
  a_opt_flags: assert property (
    frame_go |-> ##16 tx_data_r[1:0] == $past(opt_byte[1:0], 16))
    else $error("options flags not carried");
  a_no_gap: assert property (tx_valid_r && !tx_eof_r |=> tx_valid_r)
    else $error("gap inside frame");
  a_checksum: assert property (tx_eof_r |-> tx_data_r == 8'hFF - hsum_h)
    else $error("checksum wrong");
  a_drop_sel: assert property (
    commit_go && !mode_std && !mode_expl |=> pkt_drop_r && !tx_valid_r)
    else $error("non-standard select was framed");

  c_std_frame:  cover property (tx_sof_r && !expl_r ##[1:300] tx_eof_r);
  c_expl_frame: cover property (tx_sof_r && expl_r);
  c_empty_pay:  cover property (frame_go && pay_n == 9'h000);
  c_drop:       cover property (pkt_drop_r);

endmodule : rpf_framer

`default_nettype wire

//--- rpf_params.svh
// Constants of the received-packet frame builder
// Assumes inclusion by bare name from the framer and its package users
`ifndef RPF_PARAMS_SVH
`define RPF_PARAMS_SVH

// Fixed frame field values
`define RPF_START_DELIM   8'h7E
`define RPF_TYPE_STD      8'h90
`define RPF_TYPE_EXPL     8'h91
`define RPF_RSVD_WORD     16'hFFFE
`define RPF_CSUM_BASE     8'hFF

// Field positions
`define RPF_HDR_LAST      4'hE
`define RPF_CSUM_FIRST    4'h3
`define RPF_SEL_EXPL_BIT  1
`define RPF_FIXED_BYTES   16'h000C

// Mode and option encodings
`define RPF_SEL_STD       8'h00
`define RPF_METH_INVALID  2'h0

// Payload store geometry
`define RPF_PAY_AW        8
`define RPF_PAY_DEPTH     9'h100

`endif

//--- rpf_pkg.sv
// Types shared by the received-packet frame builder
// Assumes nothing of its surroundings
package rpf_pkg;

  // Frame emission phases
  typedef enum logic [1:0] {
    RPF_IDLE = 2'b00,
    RPF_HEAD = 2'b01,
    RPF_DATA = 2'b10,
    RPF_CSUM = 2'b11
  } rpf_state_t;

endpackage : rpf_pkg

//--- rpf_payload_mem.sv
// Payload byte store with registered read data
// Assumes one write and one read port on the same clock
`timescale 1ns/10ps
`default_nettype none

module rpf_payload_mem #(
  parameter int AW = 8
) (
  // Clock
  input  wire logic          ref_clk,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [7:0]    wr_data,
  // Read port
  input  wire logic [AW-1:0] rd_addr,
  output var  logic [7:0]    rd_data_r
);

  // Storage, no reset so it maps onto RAM
  logic [7:0] mem_r [0:(1<<AW)-1];

  // Write side
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  // Read side, one cycle latency
  always_ff @(posedge ref_clk) begin
    rd_data_r <= mem_r[rd_addr];
  end

endmodule : rpf_payload_mem

`default_nettype wire

//--- rpf_host_model.sv
// Host-side sink for the frame stream: collects each frame, checks it
// Assumes the framer drives tx_* from registers on ref_clk
`timescale 1ns/10ps
`default_nettype none
module rpf_host_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  // Frame byte stream
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_sof,
  input  wire logic       tx_eof,
  // Frame status
  output var  int         frames,
  output var  logic       csum_ok,
  output var  logic       gap_err
);
  logic [7:0] rx_q[$];   // Bytes of the last frame
  logic [7:0] sum;       // Sum from the type byte on
  logic       in_frame;  // Between delimiter and checksum
  // Host takes a byte every valid cycle; it has no way to stall
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      frames = 0;
      csum_ok = 1'b0;
      gap_err = 1'b0;
      in_frame = 1'b0;
    end else begin
      if (in_frame && !tx_valid) gap_err = 1'b1;
      if (tx_valid && tx_sof) begin
        rx_q = {};
        sum = 8'h00;
        in_frame = 1'b1;
      end
      if (tx_valid) rx_q.push_back(tx_data);
      if (tx_valid && rx_q.size() > 3) sum += tx_data;
      if (tx_valid && tx_eof) begin
        csum_ok = (sum == 8'hFF);
        in_frame = 1'b0;
        frames++;
      end
    end
  end
endmodule : rpf_host_model
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the received-packet frame builder
// Assumes the host model as the byte sink; expected frames built here
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        ref_clk, arst_n;  // Clock and reset
  logic        pkt_wr_valid, pkt_commit, pkt_acked, pkt_bcast;
  logic [7:0]  pkt_wr_data, api_output_select, tx_data;
  logic [63:0] pkt_src_addr;
  logic [1:0]  pkt_method;
  logic        pkt_ready, pkt_drop, tx_valid, tx_sof, tx_eof, csum_ok, gap_err;
  int          frames;
  int          n_mismatch = 0;
  int          total_checks = 0;

  rpf_framer i_rpf_framer (.ref_clk(ref_clk), .arst_n(arst_n), .pkt_wr_valid(pkt_wr_valid),
    .pkt_wr_data(pkt_wr_data), .pkt_commit(pkt_commit), .pkt_src_addr(pkt_src_addr),
    .pkt_acked(pkt_acked), .pkt_bcast(pkt_bcast), .pkt_method(pkt_method),
    .api_output_select(api_output_select), .pkt_ready(pkt_ready), .pkt_drop(pkt_drop),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_sof(tx_sof), .tx_eof(tx_eof));
  rpf_host_model i_rpf_host_model (.ref_clk(ref_clk), .arst_n(arst_n), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_sof(tx_sof), .tx_eof(tx_eof), .frames(frames),
    .csum_ok(csum_ok), .gap_err(gap_err));

  // Free-running 100 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tally_and_finish();
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // One packet in, then the frame (or the drop) judged
  task automatic send(input logic [7:0] sel, input logic [1:0] meth, input logic ack,
                      input logic bc, input int n, input logic framed);
    int          k;
    int          f0;
    logic [7:0]  s;
    logic [15:0] len;
    logic [63:0] addr;
    logic [7:0]  exp_q[$];
    logic [7:0]  got[$];
    k = (n == 0) ? 1 : n;
    f0 = frames;
    len = 16'(12 + n);
    addr = 64'hF0E1_D2C3_B4A5_9687 + 64'(n);
    for (int w = 0; w < 400 && pkt_ready !== 1'b1; w++) @(negedge ref_clk);
    // Last byte shares its cycle with the commit
    for (int i = 0; i < k; i++) begin
      @(posedge ref_clk);
      pkt_wr_valid      <= (n != 0);
      pkt_wr_data       <= 8'h30 + i[7:0];
      pkt_commit        <= (i == k - 1);
      pkt_src_addr      <= addr;
      pkt_acked         <= ack;
      pkt_bcast         <= bc;
      pkt_method        <= meth;
      api_output_select <= sel;
    end
    @(posedge ref_clk);
    pkt_wr_valid <= 1'b0;
    pkt_commit   <= 1'b0;
    // Drop pulse stands only in the cycle right after the commit edge; ready stays high after a drop, low while a frame is sent
    @(negedge ref_clk);
    check(16'(pkt_drop), 16'(!framed));
    check(16'(pkt_ready), 16'(!framed));
    if (!framed) begin
      repeat (20) @(negedge ref_clk);
      check(16'(frames - f0), 16'h0000);
      return;
    end
    for (int w = 0; w < 400 && frames == f0; w++) @(negedge ref_clk);
    exp_q = {8'h7E, len[15:8], len[7:0], (sel[1] ? 8'h91 : 8'h90)};
    for (int b = 7; b >= 0; b--) exp_q.push_back(addr[8*b +: 8]);
    exp_q.push_back(8'hFF);
    exp_q.push_back(8'hFE);
    exp_q.push_back({meth, 4'h0, bc, ack});
    for (int i = 0; i < n; i++) exp_q.push_back(8'h30 + i[7:0]);
    s = 8'h00;
    for (int i = 3; i < exp_q.size(); i++) s += exp_q[i];
    exp_q.push_back(8'hFF - s);
    got = i_rpf_host_model.rx_q;
    check(16'(got.size()), 16'(exp_q.size()));
    check(got[0], 8'h7E);
    check({got[1], got[2]}, len);
    check(got[3], exp_q[3]);
    check(got[14], exp_q[14]);
    for (int b = 0; b < exp_q.size(); b++) check(got[b], exp_q[b]);
    check(csum_ok, 1'b1);
    check(gap_err, 1'b0);
  endtask : send

  // Scenarios
  task automatic t_standard();
    send(8'h00, 2'h3, 1'b1, 1'b0, 6, 1'b1);
  endtask : t_standard

  task automatic t_methods();
    send(8'h00, 2'h1, 1'b0, 1'b1, 2, 1'b1);
    send(8'h00, 2'h2, 1'b1, 1'b1, 3, 1'b1);
  endtask : t_methods

  task automatic t_explicit();
    send(8'h02, 2'h3, 1'b0, 1'b0, 4, 1'b1);
    send(8'h03, 2'h1, 1'b1, 1'b1, 1, 1'b1);
  endtask : t_explicit

  task automatic t_drop();
    send(8'h01, 2'h3, 1'b1, 1'b0, 3, 1'b0);
    send(8'h00, 2'h0, 1'b1, 1'b0, 3, 1'b0);
  endtask : t_drop

  task automatic t_sizes();
    send(8'h00, 2'h1, 1'b0, 1'b1, 0, 1'b1);
    send(8'h00, 2'h2, 1'b1, 1'b1, 256, 1'b1);
  endtask : t_sizes

  // Main sequence
  initial begin
    arst_n = 1'b0;
    pkt_wr_valid = 1'b0;
    pkt_wr_data = 8'h00;
    pkt_commit = 1'b0;
    pkt_src_addr = 64'h0;
    pkt_acked = 1'b0;
    pkt_bcast = 1'b0;
    pkt_method = 2'h0;
    api_output_select = 8'h00;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_standard();
    t_methods();
    t_explicit();
    t_drop();
    t_sizes();
    tally_and_finish();
  end

  // Watchdog well beyond the several hundred cycles needed
  initial begin
    #200us;
    n_mismatch++;
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
